// [lcd_host_bus_interface.sv]
// host command and data port of a dot-matrix display controller
// assumes the host pins are asynchronous to i_core_clk; every one passes two flip-flops first
`timescale 1ns/1ps
module lcd_host_bus_interface #(
    parameter int unsigned CLEAR_CYCLES = lcd_host_pkg::CLEAR_CYCLES_DEF
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_register_select_line,
    input  wire logic       i_read_write_line,
    input  wire logic       i_enable_strobe,
    input  wire logic       i_interface_select_pin,
    input  wire logic [7:0] i_parallel_data_lines,
    output logic      [7:0] o_parallel_data_lines,
    output logic            o_parallel_data_oe,
    output logic            o_busy_indicator,
    output logic      [6:0] o_address_pointer,
    output logic            o_bus_width_bit,
    output logic      [7:0] o_command_holding_register,
    output logic      [7:0] o_data_holding_register
);

    // =====================================================================
    // helpers
    function automatic lcd_host_pkg::op_t decode_op(input logic [7:0] c);
        lcd_host_pkg::op_t op;
        op = lcd_host_pkg::OP_NONE;
        if (c[7]) begin
            op = lcd_host_pkg::OP_HIGH_ADDR;
        end else if (c[6]) begin
            op = lcd_host_pkg::OP_LOW_ADDR;
        end else if (c[5]) begin
            op = lcd_host_pkg::OP_FUNC;
        end else if (c[4]) begin
            op = lcd_host_pkg::OP_SHIFT;
        end else if (c[3]) begin
            op = lcd_host_pkg::OP_DISPLAY;
        end else if (c[2]) begin
            op = lcd_host_pkg::OP_ENTRY;
        end else if (c[1]) begin
            op = lcd_host_pkg::OP_HOME;
        end else if (c[0]) begin
            op = lcd_host_pkg::OP_CLEAR;
        end
        return op;
    endfunction

    function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up);
        return up ? 7'(p + 7'h01) : 7'(p - 7'h01);
    endfunction

    // =====================================================================
    // pin synchronisers
    lcd_host_pkg::host_pins_t pins_in;
    lcd_host_pkg::host_pins_t sync1_reg;
    lcd_host_pkg::host_pins_t sync2_reg;
    lcd_host_pkg::host_pins_t prev_reg;

    assign pins_in = '{rs: i_register_select_line, rw: i_read_write_line, en: i_enable_strobe,
                       interface_select_pin: i_interface_select_pin, db: i_parallel_data_lines};

    // prev_reg is the synchronised sample one cycle older, so at a strobe fall it holds the last sample taken while high
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    logic parallel_mode;
    logic en_fall;
    logic ser_rise;
    assign parallel_mode = sync2_reg.interface_select_pin;
    assign en_fall       = parallel_mode & prev_reg.en & ~sync2_reg.en;
    assign ser_rise      = ~parallel_mode & sync2_reg.rs & sync2_reg.en & ~prev_reg.en;

    // =====================================================================
    // parallel byte assembly
    logic       bus_width_reg;
    logic       nib_phase_reg;
    logic [3:0] hi_nib_reg;
    logic       par_last;
    logic       par_wr_done;
    logic       par_rd_done;
    logic [7:0] par_byte;

    // high nibble travels first on db7..db4 in the 4-bit path
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            nib_phase_reg <= 1'b0;
            hi_nib_reg    <= 4'h0;
        end else if (~parallel_mode | bus_width_reg) begin
            nib_phase_reg <= 1'b0;
        end else if (en_fall) begin
            nib_phase_reg <= ~nib_phase_reg;
            if (~nib_phase_reg) begin
                hi_nib_reg <= prev_reg.db[7:4];
            end
        end
    end

    assign par_last    = bus_width_reg | nib_phase_reg;
    assign par_wr_done = en_fall & ~prev_reg.rw & par_last;
    assign par_rd_done = en_fall & prev_reg.rw & par_last;
    assign par_byte    = bus_width_reg ? prev_reg.db : {hi_nib_reg, prev_reg.db[7:4]};

    // =====================================================================
    // serial frame receiver
    logic [4:0] ser_cnt_reg;
    logic [7:0] ser_shift_reg;
    logic       ser_rs_reg;
    logic       ser_rw_reg;
    logic [3:0] ser_hi_reg;
    logic       ser_valid_reg;
    logic [7:0] ser_byte_reg;
    logic [7:0] ser_next;

    assign ser_next = {ser_shift_reg[6:0], sync2_reg.rw};

    // a bad sync byte holds the count so the window slides until five ones line up
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ser_cnt_reg   <= lcd_host_pkg::SER_CNT_ZERO;
            ser_shift_reg <= 8'h00;
            ser_rs_reg    <= 1'b0;
            ser_rw_reg    <= 1'b0;
            ser_hi_reg    <= 4'h0;
            ser_valid_reg <= 1'b0;
            ser_byte_reg  <= 8'h00;
        end else begin
            ser_valid_reg <= 1'b0;
            if (parallel_mode | ~sync2_reg.rs) begin
                ser_cnt_reg <= lcd_host_pkg::SER_CNT_ZERO;
            end else if (ser_rise) begin
                ser_shift_reg <= ser_next;
                ser_cnt_reg   <= 5'(ser_cnt_reg + 5'h01);
                case (ser_cnt_reg)
                    lcd_host_pkg::SER_SYNC_LAST: begin
                        if (ser_next[7:3] != lcd_host_pkg::SER_SYNC) begin
                            ser_cnt_reg <= ser_cnt_reg;
                        end
                        ser_rw_reg <= ser_next[2];
                        ser_rs_reg <= ser_next[1];
                    end
                    lcd_host_pkg::SER_HI_LAST: begin
                        ser_hi_reg <= ser_next[7:4];
                    end
                    lcd_host_pkg::SER_LO_LAST: begin
                        ser_cnt_reg   <= lcd_host_pkg::SER_CNT_ZERO;
                        ser_valid_reg <= ~ser_rw_reg;   // serial reads are not returned
                        ser_byte_reg  <= {ser_hi_reg, ser_next[7:4]};
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // merged write request and acceptance
    lcd_host_pkg::host_xfer_t wr;
    lcd_host_pkg::op_t        wr_op;
    logic                     accept;
    logic                     accept_cmd;
    logic                     accept_data;
    logic                     rd_data_done;
    logic                     ext_reg;
    logic [7:0]               mem_rdata;

    assign wr.valid = parallel_mode ? par_wr_done : ser_valid_reg;
    assign wr.rs    = parallel_mode ? prev_reg.rs : ser_rs_reg;
    assign wr.data  = parallel_mode ? par_byte : ser_byte_reg;
    assign wr_op    = decode_op(wr.data);

    assign accept       = wr.valid & ~o_busy_indicator;
    assign accept_cmd   = accept & ~wr.rs;
    assign accept_data  = accept & wr.rs;
    assign rd_data_done = par_rd_done & prev_reg.rs & ~o_busy_indicator;

    // =====================================================================
    // holding registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_command_holding_register <= lcd_host_pkg::CMD_RESET_VAL;
            o_data_holding_register    <= lcd_host_pkg::CMD_RESET_VAL;
        end else begin
            if (accept_cmd) begin
                o_command_holding_register <= wr.data;
            end
            if (accept_data) begin
                o_data_holding_register <= wr.data;
            end else if (rd_data_done) begin
                o_data_holding_register <= mem_rdata;
            end
        end
    end

    // =====================================================================
    // mode settings written by instruction
    logic       inc_reg;
    logic [2:0] display_ctl_reg;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_width_reg   <= lcd_host_pkg::WIDTH_RESET_VAL;
            ext_reg         <= 1'b0;
            inc_reg         <= lcd_host_pkg::INC_RESET_VAL;
            display_ctl_reg <= 3'h0;
        end else if (accept_cmd) begin
            case (wr_op)
                lcd_host_pkg::OP_FUNC: begin
                    bus_width_reg <= wr.data[lcd_host_pkg::FS_WIDTH_BIT];
                    ext_reg       <= wr.data[lcd_host_pkg::FS_EXT_BIT];
                end
                lcd_host_pkg::OP_ENTRY: begin
                    inc_reg <= wr.data[lcd_host_pkg::EM_INC_BIT];
                end
                lcd_host_pkg::OP_DISPLAY: begin
                    display_ctl_reg <= wr.data[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    assign o_bus_width_bit = bus_width_reg;

    // =====================================================================
    // address pointer and memory region
    logic [1:0] region_reg;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_address_pointer <= lcd_host_pkg::PTR_RESET_VAL;
            region_reg        <= lcd_host_pkg::REGION_TEXT;
        end else if (accept_data | rd_data_done) begin
            o_address_pointer <= step_ptr(o_address_pointer, inc_reg);
        end else if (accept_cmd) begin
            case (wr_op)
                lcd_host_pkg::OP_HIGH_ADDR: begin
                    o_address_pointer <= wr.data[6:0];
                    region_reg <= ext_reg ? lcd_host_pkg::REGION_BITMAP : lcd_host_pkg::REGION_TEXT;
                end
                lcd_host_pkg::OP_LOW_ADDR: begin
                    if (ext_reg) begin
                        o_address_pointer <= {3'h0, wr.data[lcd_host_pkg::ICON_PTR_W-1:0]};
                        region_reg        <= lcd_host_pkg::REGION_ICON;
                    end else begin
                        o_address_pointer <= {1'b0, wr.data[lcd_host_pkg::FONT_PTR_W-1:0]};
                        region_reg        <= lcd_host_pkg::REGION_FONT;
                    end
                end
                lcd_host_pkg::OP_SHIFT: begin
                    // cursor move only; a display shift leaves the pointer alone
                    if (~ext_reg & ~wr.data[lcd_host_pkg::CS_SC_BIT]) begin
                        o_address_pointer <= step_ptr(o_address_pointer, wr.data[lcd_host_pkg::CS_RL_BIT]);
                    end
                end
                lcd_host_pkg::OP_HOME, lcd_host_pkg::OP_CLEAR: begin
                    if (~ext_reg) begin
                        o_address_pointer <= lcd_host_pkg::PTR_RESET_VAL;
                        region_reg        <= lcd_host_pkg::REGION_TEXT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================================================
    // execution timer and clear sequencer
    lcd_host_pkg::exec_state_t state_reg;
    logic [lcd_host_pkg::BUSY_W-1:0] busy_cnt_reg;
    logic [6:0]                      clr_idx_reg;
    logic                            is_clear;

    assign is_clear = accept_cmd & ~ext_reg & (wr_op == lcd_host_pkg::OP_CLEAR);

    // a status read loads nothing here, so it never makes the part busy
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg    <= lcd_host_pkg::ST_IDLE;
            busy_cnt_reg <= '0;
            clr_idx_reg  <= 7'h00;
        end else if (accept | rd_data_done) begin
            busy_cnt_reg <= is_clear ? CLEAR_CYCLES[lcd_host_pkg::BUSY_W-1:0]
                                     : lcd_host_pkg::BUSY_W'(lcd_host_pkg::EXEC_CYCLES);
            state_reg    <= is_clear ? lcd_host_pkg::ST_CLEAR : lcd_host_pkg::ST_IDLE;
            clr_idx_reg  <= 7'h00;
        end else begin
            if (busy_cnt_reg != '0) begin
                busy_cnt_reg <= busy_cnt_reg - lcd_host_pkg::BUSY_W'(1);
            end
            case (state_reg)
                lcd_host_pkg::ST_CLEAR: begin
                    clr_idx_reg <= 7'(clr_idx_reg + 7'h01);
                    if (clr_idx_reg == lcd_host_pkg::CLEAR_LAST_IDX) begin
                        state_reg <= lcd_host_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= lcd_host_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign o_busy_indicator = (busy_cnt_reg != '0) | (state_reg == lcd_host_pkg::ST_CLEAR);

    // =====================================================================
    // memory port: clear fill takes priority since the host is locked out then
    logic                            mem_we;
    logic [lcd_host_pkg::MEM_AW-1:0] mem_addr;
    logic [7:0]                      mem_wdata;
    logic                            clearing;

    assign clearing  = (state_reg == lcd_host_pkg::ST_CLEAR);
    assign mem_we    = clearing | accept_data;
    assign mem_addr  = clearing ? {lcd_host_pkg::REGION_TEXT, clr_idx_reg} : {region_reg, o_address_pointer};
    assign mem_wdata = clearing ? lcd_host_pkg::CLEAR_FILL : wr.data;

    display_mem u_mem (
        .i_core_clk (i_core_clk),
        .i_we       (mem_we),
        .i_addr     (mem_addr),
        .i_wdata    (mem_wdata),
        .o_rdata    (mem_rdata)
    );

    // =====================================================================
    // read drive: status or memory byte, split into nibbles on the 4-bit path
    logic [7:0] rd_full;

    assign rd_full            = sync2_reg.rs ? mem_rdata : {o_busy_indicator, o_address_pointer};
    assign o_parallel_data_oe = parallel_mode & sync2_reg.en & sync2_reg.rw;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_parallel_data_lines <= 8'h00;
        end else if (bus_width_reg) begin
            o_parallel_data_lines <= rd_full;
        end else begin
            o_parallel_data_lines <= nib_phase_reg ? {rd_full[3:0], 4'h0} : {rd_full[7:4], 4'h0};
        end
    end

endmodule

// [lcd_host_pkg.sv]
// constants, field layouts and carrier types shared by the host bus port and its memory
// assumes a single core clock at 20 MHz; all times below are turned into cycles of it
package lcd_host_pkg;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int EXEC_TIME_NS     = 72000;      // ordinary instruction or data access
    localparam int CLEAR_TIME_NS    = 1600000;    // clear fills the whole text memory
    // least times, so round up to whole cycles
    localparam int EXEC_CYCLES      = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYCLES_DEF = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W           = 16;

    // =====================================================================
    // widths
    localparam int DATA_W   = 8;
    localparam int PTR_W    = 7;
    localparam int REGION_W = 2;
    localparam int MEM_AW   = REGION_W + PTR_W;
    localparam int NIB_W    = 4;

    // =====================================================================
    // memory regions behind the data holding register
    localparam logic [1:0] REGION_TEXT   = 2'h0;
    localparam logic [1:0] REGION_FONT   = 2'h1;
    localparam logic [1:0] REGION_BITMAP = 2'h2;
    localparam logic [1:0] REGION_ICON   = 2'h3;

    // =====================================================================
    // reset values and fill pattern
    localparam logic [7:0] CLEAR_FILL      = 8'h20;
    localparam logic [7:0] CMD_RESET_VAL   = 8'h00;
    localparam logic [6:0] PTR_RESET_VAL   = 7'h00;
    localparam logic       WIDTH_RESET_VAL = 1'b1;   // 8-bit path after reset
    localparam logic       INC_RESET_VAL   = 1'b1;
    localparam logic [6:0] CLEAR_LAST_IDX  = 7'h7f;

    // =====================================================================
    // field positions and pointer widths inside instructions
    localparam int FS_WIDTH_BIT = 4;
    localparam int FS_EXT_BIT   = 2;
    localparam int EM_INC_BIT   = 1;
    localparam int EM_SHIFT_BIT = 0;
    localparam int CS_SC_BIT    = 3;
    localparam int CS_RL_BIT    = 2;
    localparam int ICON_PTR_W   = 4;
    localparam int FONT_PTR_W   = 6;

    // =====================================================================
    // serial framing: sync byte 11111 rw rs 0, then two nibble bytes
    localparam logic [4:0] SER_SYNC      = 5'h1f;
    localparam logic [4:0] SER_SYNC_LAST = 5'h07;
    localparam logic [4:0] SER_HI_LAST   = 5'h0f;
    localparam logic [4:0] SER_LO_LAST   = 5'h17;
    localparam logic [4:0] SER_CNT_ZERO  = 5'h00;

    // =====================================================================
    // types
    typedef struct packed {
        logic       rs;
        logic       rw;
        logic       en;
        logic       interface_select_pin;
        logic [7:0] db;
    } host_pins_t;

    typedef struct packed {
        logic       valid;
        logic       rs;
        logic [7:0] data;
    } host_xfer_t;

    typedef enum {ST_IDLE, ST_CLEAR} exec_state_t;

    typedef enum {OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISPLAY, OP_SHIFT,
                  OP_FUNC, OP_LOW_ADDR, OP_HIGH_ADDR} op_t;

endpackage

// [display_mem.sv]
// byte-wide single-port store holding text, font, bitmap and icon regions
// assumes one access per cycle; read data are registered and follow the address one cycle later
`timescale 1ns/1ps
module display_mem (
    input  wire logic                             i_core_clk,
    input  wire logic                             i_we,
    input  wire logic [lcd_host_pkg::MEM_AW-1:0]  i_addr,
    input  wire logic [lcd_host_pkg::DATA_W-1:0]  i_wdata,
    output logic      [lcd_host_pkg::DATA_W-1:0]  o_rdata
);

    // =====================================================================
    // storage
    logic [lcd_host_pkg::DATA_W-1:0] mem_reg [0:(1 << lcd_host_pkg::MEM_AW)-1];

    // write port; contents are not reset, software clears the text region by instruction
    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            mem_reg[i_addr] <= i_wdata;
        end
    end

    // registered read, write-first so a just-written byte reads back at once
    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem_reg[i_addr];
        end
    end

endmodule

// [lcd_host_bus_interface_monitor.sv]
// checker for the host bus port, bound to its top module
// assumes pins change only just after rising clock edges
`timescale 1ns/1ps
module lcd_host_bus_interface_monitor #(
    parameter int unsigned CLEAR_CYCLES = 200
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic       i_register_select_line,
    input wire logic       i_read_write_line,
    input wire logic       i_enable_strobe,
    input wire logic       i_interface_select_pin,
    input wire logic [7:0] o_parallel_data_lines,
    input wire logic       o_parallel_data_oe,
    input wire logic       o_busy_indicator,
    input wire logic [6:0] o_address_pointer,
    input wire logic       o_bus_width_bit,
    input wire logic [7:0] o_command_holding_register,
    input wire logic [7:0] o_data_holding_register
);
    // =======
    // properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] run_reg;
    // busy run length, so a wrong timer constant shows at the fall
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) run_reg <= 16'h0000;
        else run_reg <= o_busy_indicator ? run_reg + 16'h0001 : 16'h0000;
    end
    chk_read_drive_en: assert property (o_parallel_data_oe ==
        $past(i_interface_select_pin & i_enable_strobe & i_read_write_line, 2)) else $error("bad drive");
    chk_status_byte: assert property (o_parallel_data_oe && $past(o_parallel_data_oe)
        && $past(o_bus_width_bit) && !$past(i_register_select_line, 3) |-> o_parallel_data_lines ==
        {$past(o_busy_indicator), $past(o_address_pointer)}) else $error("bad status");
    chk_cmd_when_idle: assert property ($changed(o_command_holding_register)
        |-> o_busy_indicator && !$past(o_busy_indicator)) else $error("bad accept");
    chk_busy_blocks: assert property (o_busy_indicator && $past(o_busy_indicator)
        |-> $stable(o_command_holding_register)) else $error("taken while busy");
    chk_ptr_one_step: assert property ($changed(o_address_pointer)
        && $stable(o_command_holding_register) && o_command_holding_register != 8'h01
        |-> $rose(o_busy_indicator) && (o_address_pointer == $past(o_address_pointer) + 7'h01
        || o_address_pointer == $past(o_address_pointer) - 7'h01)) else $error("bad step");
    chk_width_by_func: assert property ($changed(o_bus_width_bit)
        |-> $changed(o_command_holding_register) && o_command_holding_register[7:5] == 3'b001
        && o_bus_width_bit == o_command_holding_register[4]) else $error("bad width");
    chk_busy_run_len: assert property ($fell(o_busy_indicator) |-> run_reg inside
        {[lcd_host_pkg::EXEC_CYCLES-1:lcd_host_pkg::EXEC_CYCLES+1], [CLEAR_CYCLES-1:CLEAR_CYCLES+1]})
        else $error("bad busy length");
    chk_data_when_idle: assert property ($changed(o_data_holding_register)
        |-> !$past(o_busy_indicator)) else $error("data taken while busy");
    cover property ($rose(o_busy_indicator));
    cover property ($fell(o_bus_width_bit));
    cover property (o_parallel_data_oe && !i_register_select_line);
endmodule
bind lcd_host_bus_interface lcd_host_bus_interface_monitor #(.CLEAR_CYCLES(CLEAR_CYCLES))
    i_lcd_host_bus_interface_monitor (.i_core_clk, .i_rst, .i_register_select_line, .i_read_write_line,
    .i_enable_strobe, .i_interface_select_pin, .o_parallel_data_lines, .o_parallel_data_oe,
    .o_busy_indicator, .o_address_pointer, .o_bus_width_bit, .o_command_holding_register,
    .o_data_holding_register);

// [lcd_host_mpu_model.sv]
// host model: drives the port pins as a microprocessor would
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ps
module lcd_host_mpu_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_data,
    output logic            o_rs,
    output logic            o_rw,
    output logic            o_en,
    output logic            o_psb,
    output logic      [7:0] o_db
);
    // =======
    // pin tasks
    initial {o_rs, o_rw, o_en, o_psb, o_db} = 12'h100;
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // one strobe; selects settle well ahead since the pins are synchronised
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] db, output logic [7:0] q);
        o_rs <= rs;
        o_rw <= rw;
        o_db <= rw ? ~o_db : db; // released bus shows no stale byte
        tick(4);
        o_en <= 1'b1;
        tick(6);
        q = i_data;
        o_en <= 1'b0;
        tick(5);
    endtask
    // serial frame, msb first; clock idles low outside the frame
    task automatic serial(input logic [7:0] sync, input logic [7:0] b);
        logic [23:0] frame;
        frame = {sync, b[7:4], 4'h0, b[3:0], 4'h0};
        o_psb <= 1'b0;
        tick(4);
        o_rs <= 1'b1;
        tick(4);
        for (int i = 23; i >= 0; i--) begin
            o_rw <= frame[i];
            tick(3);
            o_en <= 1'b1;
            tick(3);
            o_en <= 1'b0;
        end
        tick(8);
        o_rs <= 1'b0;
        o_psb <= 1'b1;
        tick(4);
    endtask
endmodule

// [test_lcd_host_bus_interface.sv]
// self-checking bench for the host bus port
// assumes the host model moves pins only after rising edges
`timescale 1ns/1ps
module test_lcd_host_bus_interface;
    localparam int unsigned CLEAR_CYCLES = 200;  // short clear keeps the run brief
    logic       i_core_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       rs, rw, en, interface_select_pin, oe, busy, width;
    logic       nib = 1'b0;
    logic [7:0] host_db, pin_db, dev_db, cmd, dr, q;
    logic [6:0] ptr;
    int         num_errors = 0;
    int         checks_done = 0;
    always #25 i_core_clk = ~i_core_clk;
    // shared data wire: the device wins while it drives
    assign pin_db = oe ? dev_db : host_db;
    lcd_host_bus_interface #(.CLEAR_CYCLES(CLEAR_CYCLES)) i_lcd_host_bus_interface (.i_core_clk, .i_rst,
        .i_register_select_line(rs), .i_read_write_line(rw), .i_enable_strobe(en),
        .i_interface_select_pin(interface_select_pin), .i_parallel_data_lines(pin_db), .o_parallel_data_lines(dev_db),
        .o_parallel_data_oe(oe), .o_busy_indicator(busy), .o_address_pointer(ptr),
        .o_bus_width_bit(width), .o_command_holding_register(cmd), .o_data_holding_register(dr));
    lcd_host_mpu_model i_lcd_host_mpu_model (.i_core_clk, .i_data(pin_db), .o_rs(rs), .o_rw(rw),
        .o_en(en), .o_psb(interface_select_pin), .o_db(host_db));
    // =======
    // tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // in 4-bit mode every transfer takes two strobes to keep the nibble phase
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 200; i++) begin
            i_lcd_host_mpu_model.xfer(1'b0, 1'b1, 8'h00, s);
            if (nib) i_lcd_host_mpu_model.xfer(1'b0, 1'b1, 8'h00, q);
            if (s[7] === 1'b0) return;
        end
        num_errors++;
        stop_test();
    endtask
    task automatic put(input logic r, input logic [7:0] b);
        wait_idle();
        if (nib) i_lcd_host_mpu_model.xfer(r, 1'b0, {b[7:4], 4'h0}, q);
        i_lcd_host_mpu_model.xfer(r, 1'b0, nib ? {b[3:0], 4'h0} : b, q);
    endtask
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        check({width, ptr}, 8'h80);
        check(cmd, 8'h00);
        put(1'b0, 8'h85);
        check(cmd, 8'h85);
        check({busy, ptr}, 8'h85);
        i_lcd_host_mpu_model.xfer(1'b0, 1'b1, 8'h00, q);
        check(q, 8'h85);
        i_lcd_host_mpu_model.xfer(1'b0, 1'b0, 8'h90, q);
        check(cmd, 8'h85);
        put(1'b1, 8'ha5);
        check(dr, 8'ha5);
        check({1'b0, ptr}, 8'h06);
        put(1'b0, 8'h04);
        put(1'b1, 8'h3c);
        check({1'b0, ptr}, 8'h05);
        put(1'b0, 8'h86);
        wait_idle();
        i_lcd_host_mpu_model.xfer(1'b1, 1'b1, 8'h00, q);
        check(q, 8'h3c);
        check({busy, ptr}, 8'h85);
        put(1'b0, 8'h20);
        check({width, ptr}, 8'h05);
        nib = 1'b1;
        put(1'b0, 8'h84);
        check(cmd, 8'h84);
        put(1'b0, 8'h30);
        nib = 1'b0;
        check({width, ptr}, 8'h84);
        wait_idle();
        i_lcd_host_mpu_model.serial(8'hf8, 8'h83);
        check(cmd, 8'h83);
        check({busy, ptr}, 8'h83);
        // clear fills text memory with spaces and homes the pointer
        put(1'b0, 8'h01);
        check({busy, ptr}, 8'h80);
        wait_idle();
        i_lcd_host_mpu_model.xfer(1'b1, 1'b1, 8'h00, q);
        check(q, 8'h20);
        check({busy, ptr}, 8'hff);
        stop_test();
    end
endmodule
